// ===== logic/pmbus_fault_status_consts.vh
// How it works
// - output-voltage byte bit 7 latches an output overvoltage fault until cleared.
// - output-voltage byte bit 6 latches an output overvoltage warning until cleared.
// - bit 5 latches undervoltage warning, bit 4 undervoltage fault, both sticky.
// - bit 3 latches when commanded output voltage breaks the min/max limit.
// - bit 2 latches when the start-up turn-on time limit runs out.
// - output-voltage bits 1 and 0 always read zero and ignore writes.
// - one overvoltage-fault mask covers fixed, tracking and pre-bias; extended mask splits them.
// - a clear-faults command or writing 1 to a flag clears it; 0 keeps it.
// - output-current byte bit 7 latches an overcurrent fault until cleared.
// - output-current byte bit 5 latches an overcurrent warning until cleared.
// - output-current bit 6 and bits 4 to 0 read zero, read-only.
// - input byte bit 7 latches an input overvoltage fault until cleared.
// - input byte bit 6, overvoltage warning, is unsupported and reads zero.
// - input byte bit 5 latches an input undervoltage warning and may raise alert.
// - input undervoltage warning stays masked until input first passes turn-on after reset.
// - input byte bit 3 is live: 0 when the input is on, 1 when off.
// - live low-input bit reads 1 when input or 5 V bias blocks conversion.
// - low-input bit is 1 from reset and never raises the alert.
// - every alert-capable flag has a mask bit; alert only on unmasked setting.
// - bytes answer one-byte read and write commands at codes 7A, 7B, 7C, 7D.
// - each summary bit is the OR of its byte's supported flags.
`ifndef PMBUS_FAULT_STATUS_CONSTS_VH
`define PMBUS_FAULT_STATUS_CONSTS_VH

// command codes
`define CMD_OUTPUT_VOLTAGE_STATUS 8'h7A
`define CMD_OUTPUT_CURRENT_STATUS 8'h7B
`define CMD_INPUT_SUPPLY_STATUS 8'h7C
`define CMD_TEMPERATURE_STATUS 8'h7D

// output-voltage byte
`define OUT_OVERVOLT_FAULT_BIT 7
`define OUT_OVERVOLT_WARN_BIT 6
`define OUT_UNDERVOLT_WARN_BIT 5
`define OUT_UNDERVOLT_FAULT_BIT 4
`define OUT_LIMIT_VIOLATION_BIT 3
`define STARTUP_TIMEOUT_BIT 2
`define VOUT_SUPPORTED 8'hFC

// output-current byte
`define OVERCURRENT_FAULT_BIT 7
`define OVERCURRENT_WARN_BIT 5
`define IOUT_SUPPORTED 8'hA0

// input byte
`define INPUT_OVERVOLT_FAULT_BIT 7
`define INPUT_UNDERVOLT_WARN_BIT 5
`define INPUT_OFF_LIVE_BIT 3
`define INPUT_SUPPORTED 8'hA0

// temperature byte
`define OVERTEMP_FAULT_BIT 7
`define OVERTEMP_WARN_BIT 6
`define TEMP_SUPPORTED 8'hC0

// extended overvoltage mask fields
`define EXT_MASK_FIXED 0
`define EXT_MASK_TRACKING 1
`define EXT_MASK_PREBIAS 2

// reset values
`define FLAGS_RESET 8'h00
`define BYTE_ZERO 8'h00
`define BYTE_ALL 8'hFF
`define INPUT_OFF_RESET 1'b1

`endif

// ===== logic/status_flag_bank.v
`timescale 1ns/1ps
module status_flag_bank (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // flag control
  input wire [7:0] setPulse,
  input wire [7:0] clearBits,
  input wire [7:0] supported,
  // state
  output reg [7:0] flags_reg
);
`include "pmbus_fault_status_consts.vh"

  reg [7:0] flags_next;

  // set is applied after clear so a coinciding event is never lost
  always @* begin
    flags_next = ((flags_reg & ~clearBits) | setPulse) & supported;
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      flags_reg <= `FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end
endmodule // status_flag_bank

// ===== logic/level_sync.v
`timescale 1ns/1ps
module level_sync (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  input wire resetLevel,
  // asynchronous level in, filtered level out
  input wire asyncIn,
  output reg level_reg
);
  reg stage1_reg;
  reg stage2_reg;
  reg stage3_reg;

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
      stage3_reg <= 1'b0;
    end else begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // resetLevel is not used here; level_reg always resets to 0 whatever the instance ties it to
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      level_reg <= 1'b0;
    end else if (stage2_reg == stage3_reg) begin
      level_reg <= stage3_reg;
    end
  end
endmodule // level_sync

// ===== logic/pmbus_fault_status_regs.v
`timescale 1ns/1ps
module pmbus_fault_status_regs (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // decoded one-byte command port
  input wire cmdStrobe,
  input wire cmdIsWrite,
  input wire [7:0] cmdCode,
  input wire [7:0] cmdWriteData,
  input wire clearFaultsCmd,
  output reg [7:0] readData_reg,
  output reg readValid_reg,
  output reg cmdRejected_reg,
  // output voltage detectors, one-cycle pulses
  input wire ovFixedEvt,
  input wire ovTrackingEvt,
  input wire ovPrebiasEvt,
  input wire outOvWarnEvt,
  input wire outUvWarnEvt,
  input wire outUvFaultEvt,
  input wire outLimitEvt,
  input wire startupTimeoutEvt,
  // output current and temperature detectors, one-cycle pulses
  input wire overcurrentFaultEvt,
  input wire overcurrentWarnEvt,
  input wire overtempFaultEvt,
  input wire overtempWarnEvt,
  // input supply detectors
  input wire inputOvFaultEvt,
  input wire inputUvWarnEvt,
  input wire powerInputOnAsync,
  input wire bias5vOkAsync,
  // alert masks, 1 suppresses the alert
  input wire [7:0] voutAlertMask,
  input wire [7:0] ioutAlertMask,
  input wire [7:0] inputAlertMask,
  input wire [7:0] tempAlertMask,
  input wire [2:0] alertMaskExt,
  // summary and alert
  output reg voutSummary_reg,
  output reg ioutSummary_reg,
  output reg inputSummary_reg,
  output reg tempSummary_reg,
  output reg smbAlert_reg
);
`include "pmbus_fault_status_consts.vh"

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  // clear pattern for one byte: clear-faults wipes all, a write clears the 1 positions
  function [7:0] clearFor;
    input [7:0] code;
    input [7:0] target;
    input strobe;
    input isWrite;
    input [7:0] data;
    input clearAll;
    begin
      if (clearAll) begin
        clearFor = `BYTE_ALL;
      end else if (strobe && isWrite && code == target) begin
        clearFor = data;
      end else begin
        clearFor = `BYTE_ZERO;
      end
    end
  endfunction

  function knownCode;
    input [7:0] code;
    begin
      knownCode = (code == `CMD_OUTPUT_VOLTAGE_STATUS) || (code == `CMD_OUTPUT_CURRENT_STATUS) ||
        (code == `CMD_INPUT_SUPPLY_STATUS) || (code == `CMD_TEMPERATURE_STATUS);
    end
  endfunction

  wire [7:0] voutClear;
  wire [7:0] ioutClear;
  wire [7:0] inputClear;
  wire [7:0] tempClear;

  assign voutClear = clearFor(cmdCode, `CMD_OUTPUT_VOLTAGE_STATUS, cmdStrobe, cmdIsWrite, cmdWriteData,
    clearFaultsCmd);
  assign ioutClear = clearFor(cmdCode, `CMD_OUTPUT_CURRENT_STATUS, cmdStrobe, cmdIsWrite, cmdWriteData,
    clearFaultsCmd);
  assign inputClear = clearFor(cmdCode, `CMD_INPUT_SUPPLY_STATUS, cmdStrobe, cmdIsWrite, cmdWriteData,
    clearFaultsCmd);
  assign tempClear = clearFor(cmdCode, `CMD_TEMPERATURE_STATUS, cmdStrobe, cmdIsWrite, cmdWriteData,
    clearFaultsCmd);

  ////////////////////////////////////////////////////////////////////////////
  // live input state

  wire powerInputOn;
  wire bias5vOk;
  reg inputOff_reg;
  reg inputSeenOn_reg;

  level_sync inputOnSync (
    .clock(clock),
    .sys_rst(sys_rst),
    .resetLevel(1'b0),
    .asyncIn(powerInputOnAsync),
    .level_reg(powerInputOn)
  );

  level_sync biasOkSync (
    .clock(clock),
    .sys_rst(sys_rst),
    .resetLevel(1'b0),
    .asyncIn(bias5vOkAsync),
    .level_reg(bias5vOk)
  );

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      inputOff_reg <= `INPUT_OFF_RESET;
      inputSeenOn_reg <= 1'b0;
    end else begin
      // either rail blocks conversion, so either one marks the input off
      inputOff_reg <= ~(powerInputOn & bias5vOk);
      if (powerInputOn) begin
        inputSeenOn_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag set vectors

  reg [7:0] voutSet;
  reg [7:0] ioutSet;
  reg [7:0] inputSet;
  reg [7:0] tempSet;
  reg ovAlertCause;

  always @* begin
    voutSet = `BYTE_ZERO;
    voutSet[`OUT_OVERVOLT_FAULT_BIT] = ovFixedEvt | ovTrackingEvt | ovPrebiasEvt;
    voutSet[`OUT_OVERVOLT_WARN_BIT] = outOvWarnEvt;
    voutSet[`OUT_UNDERVOLT_WARN_BIT] = outUvWarnEvt;
    voutSet[`OUT_UNDERVOLT_FAULT_BIT] = outUvFaultEvt;
    voutSet[`OUT_LIMIT_VIOLATION_BIT] = outLimitEvt;
    voutSet[`STARTUP_TIMEOUT_BIT] = startupTimeoutEvt;
    ioutSet = `BYTE_ZERO;
    ioutSet[`OVERCURRENT_FAULT_BIT] = overcurrentFaultEvt;
    ioutSet[`OVERCURRENT_WARN_BIT] = overcurrentWarnEvt;
    inputSet = `BYTE_ZERO;
    inputSet[`INPUT_OVERVOLT_FAULT_BIT] = inputOvFaultEvt;
    inputSet[`INPUT_UNDERVOLT_WARN_BIT] = inputUvWarnEvt;
    tempSet = `BYTE_ZERO;
    tempSet[`OVERTEMP_FAULT_BIT] = overtempFaultEvt;
    tempSet[`OVERTEMP_WARN_BIT] = overtempWarnEvt;
    // each overvoltage source has its own extended mask under the shared one
    ovAlertCause = (ovFixedEvt & ~alertMaskExt[`EXT_MASK_FIXED]) |
      (ovTrackingEvt & ~alertMaskExt[`EXT_MASK_TRACKING]) |
      (ovPrebiasEvt & ~alertMaskExt[`EXT_MASK_PREBIAS]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // alert causes

  reg [7:0] voutAlertSet;
  reg [7:0] inputAlertSet;

  always @* begin
    voutAlertSet = voutSet & ~voutAlertMask;
    voutAlertSet[`OUT_OVERVOLT_FAULT_BIT] = ovAlertCause & ~voutAlertMask[`OUT_OVERVOLT_FAULT_BIT];
    inputAlertSet = inputSet & ~inputAlertMask;
    // undervoltage warning cannot alert before the input has ever come up
    inputAlertSet[`INPUT_UNDERVOLT_WARN_BIT] = inputSet[`INPUT_UNDERVOLT_WARN_BIT] &
      ~inputAlertMask[`INPUT_UNDERVOLT_WARN_BIT] & inputSeenOn_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // latched flags and pending alerts

  wire [7:0] voutFlags;
  wire [7:0] ioutFlags;
  wire [7:0] inputFlags;
  wire [7:0] tempFlags;
  wire [7:0] voutAlerts;
  wire [7:0] ioutAlerts;
  wire [7:0] inputAlerts;
  wire [7:0] tempAlerts;

  // unsupported positions are forced to zero by the support masks
  status_flag_bank voutBank (
    .clock(clock),
    .sys_rst(sys_rst),
    .setPulse(voutSet),
    .clearBits(voutClear),
    .supported(`VOUT_SUPPORTED),
    .flags_reg(voutFlags)
  );

  status_flag_bank ioutBank (
    .clock(clock),
    .sys_rst(sys_rst),
    .setPulse(ioutSet),
    .clearBits(ioutClear),
    .supported(`IOUT_SUPPORTED),
    .flags_reg(ioutFlags)
  );

  status_flag_bank inputBank (
    .clock(clock),
    .sys_rst(sys_rst),
    .setPulse(inputSet),
    .clearBits(inputClear),
    .supported(`INPUT_SUPPORTED),
    .flags_reg(inputFlags)
  );

  status_flag_bank tempBank (
    .clock(clock),
    .sys_rst(sys_rst),
    .setPulse(tempSet),
    .clearBits(tempClear),
    .supported(`TEMP_SUPPORTED),
    .flags_reg(tempFlags)
  );

  // pending alerts clear together with their flags, so the alert drops once serviced
  status_flag_bank voutAlertBank (
    .clock(clock),
    .sys_rst(sys_rst),
    .setPulse(voutAlertSet),
    .clearBits(voutClear),
    .supported(`VOUT_SUPPORTED),
    .flags_reg(voutAlerts)
  );

  status_flag_bank ioutAlertBank (
    .clock(clock),
    .sys_rst(sys_rst),
    .setPulse(ioutSet & ~ioutAlertMask),
    .clearBits(ioutClear),
    .supported(`IOUT_SUPPORTED),
    .flags_reg(ioutAlerts)
  );

  // live low-input bit is outside this bank, so it can never alert
  status_flag_bank inputAlertBank (
    .clock(clock),
    .sys_rst(sys_rst),
    .setPulse(inputAlertSet),
    .clearBits(inputClear),
    .supported(`INPUT_SUPPORTED),
    .flags_reg(inputAlerts)
  );

  status_flag_bank tempAlertBank (
    .clock(clock),
    .sys_rst(sys_rst),
    .setPulse(tempSet & ~tempAlertMask),
    .clearBits(tempClear),
    .supported(`TEMP_SUPPORTED),
    .flags_reg(tempAlerts)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read path

  reg [7:0] readByte;

  always @* begin
    case (cmdCode)
      `CMD_OUTPUT_VOLTAGE_STATUS: begin
        readByte = voutFlags;
      end
      `CMD_OUTPUT_CURRENT_STATUS: begin
        readByte = ioutFlags;
      end
      `CMD_INPUT_SUPPLY_STATUS: begin
        readByte = inputFlags;
        // written value at this position is ignored; it only mirrors the rails
        readByte[`INPUT_OFF_LIVE_BIT] = inputOff_reg;
      end
      `CMD_TEMPERATURE_STATUS: begin
        readByte = tempFlags;
      end
      default: begin
        readByte = `BYTE_ZERO;
      end
    endcase
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      readData_reg <= `BYTE_ZERO;
      readValid_reg <= 1'b0;
      cmdRejected_reg <= 1'b0;
    end else begin
      readValid_reg <= cmdStrobe & ~cmdIsWrite & knownCode(cmdCode);
      cmdRejected_reg <= cmdStrobe & ~knownCode(cmdCode);
      if (cmdStrobe && !cmdIsWrite) begin
        readData_reg <= readByte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // summary bits and alert

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      voutSummary_reg <= 1'b0;
      ioutSummary_reg <= 1'b0;
      inputSummary_reg <= 1'b0;
      tempSummary_reg <= 1'b0;
      smbAlert_reg <= 1'b0;
    end else begin
      // follows the flags one cycle late; a set in flight reaches the summary two cycles later
      voutSummary_reg <= |voutFlags;
      ioutSummary_reg <= |ioutFlags;
      inputSummary_reg <= |inputFlags;
      tempSummary_reg <= |tempFlags;
      smbAlert_reg <= |{voutAlerts, ioutAlerts, inputAlerts, tempAlerts};
    end
  end
endmodule // pmbus_fault_status_regs

// ===== tb/pmbus_fault_status_monitor.sv
`timescale 1ns/1ps
module pmbus_fault_status_monitor (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // command port
  input wire cmdStrobe,
  input wire cmdIsWrite,
  input wire [7:0] cmdCode,
  input wire clearFaultsCmd,
  input wire [7:0] readData_reg,
  input wire readValid_reg,
  input wire cmdRejected_reg,
  // output voltage events
  input wire ovFixedEvt,
  input wire ovTrackingEvt,
  input wire ovPrebiasEvt,
  input wire outOvWarnEvt,
  input wire outUvWarnEvt,
  input wire outUvFaultEvt,
  input wire outLimitEvt,
  input wire startupTimeoutEvt,
  // summaries and alert
  input wire voutSummary_reg,
  input wire ioutSummary_reg,
  input wire inputSummary_reg,
  input wire tempSummary_reg,
  input wire smbAlert_reg
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire knownCode = (cmdCode >= 8'h7A) && (cmdCode <= 8'h7D);
  // any write to the byte is treated as a clear, which keeps the hold check conservative
  wire voutClr = clearFaultsCmd || (cmdStrobe && cmdIsWrite && (cmdCode == 8'h7A));
  wire voutEvt = ovFixedEvt | ovTrackingEvt | ovPrebiasEvt | outOvWarnEvt | outUvWarnEvt | outUvFaultEvt
    | outLimitEvt | startupTimeoutEvt;
  wire anySummary = voutSummary_reg | ioutSummary_reg | inputSummary_reg | tempSummary_reg;
  sequence readOf(code);
    cmdStrobe && !cmdIsWrite && (cmdCode == code);
  endsequence
  sequence flagHeld;
    !voutClr ##1 voutSummary_reg;
  endsequence
  a_read_answer_next: assert property (cmdStrobe && !cmdIsWrite && knownCode |=> readValid_reg && !cmdRejected_reg)
    else $error("read of a known code not answered next cycle");
  a_unknown_code_refused: assert property (cmdStrobe && !knownCode |=> cmdRejected_reg && !readValid_reg)
    else $error("unknown code not refused");
  a_vout_low_zero: assert property (readOf(8'h7A) |=> readData_reg[1:0] == 2'h0)
    else $error("output voltage bits 1:0 not zero");
  a_iout_unused_zero: assert property (readOf(8'h7B) |=> (readData_reg & 8'h5F) == 8'h00)
    else $error("output current unsupported bits not zero");
  a_input_unused_zero: assert property (readOf(8'h7C) |=> (readData_reg & 8'h57) == 8'h00)
    else $error("input unsupported bits not zero");
  a_vout_summary_sets: assert property (outUvFaultEvt |-> ##2 voutSummary_reg)
    else $error("output voltage summary not set two cycles after event");
  a_vout_flag_sticky: assert property (flagHeld |=> voutSummary_reg)
    else $error("output voltage flag dropped without a clear");
  a_clear_all_drops: assert property (clearFaultsCmd && !voutEvt |-> ##2 !voutSummary_reg)
    else $error("clear faults left output voltage summary set");
  a_alert_has_cause: assert property ($rose(smbAlert_reg) |-> anySummary)
    else $error("alert rose with no flag set");
endmodule // pmbus_fault_status_monitor

bind pmbus_fault_status_regs pmbus_fault_status_monitor u_pmbus_fault_status_monitor (
  .clock(clock), .sys_rst(sys_rst), .cmdStrobe(cmdStrobe), .cmdIsWrite(cmdIsWrite), .cmdCode(cmdCode),
  .clearFaultsCmd(clearFaultsCmd), .readData_reg(readData_reg), .readValid_reg(readValid_reg),
  .cmdRejected_reg(cmdRejected_reg), .ovFixedEvt(ovFixedEvt), .ovTrackingEvt(ovTrackingEvt),
  .ovPrebiasEvt(ovPrebiasEvt), .outOvWarnEvt(outOvWarnEvt), .outUvWarnEvt(outUvWarnEvt),
  .outUvFaultEvt(outUvFaultEvt), .outLimitEvt(outLimitEvt), .startupTimeoutEvt(startupTimeoutEvt),
  .voutSummary_reg(voutSummary_reg), .ioutSummary_reg(ioutSummary_reg), .inputSummary_reg(inputSummary_reg),
  .tempSummary_reg(tempSummary_reg), .smbAlert_reg(smbAlert_reg));

// ===== tb/pmbus_host_model.sv
`timescale 1ns/1ps
module pmbus_host_model (
  // clock
  input wire clock,
  // decoded command toward the device
  output reg cmdStrobe,
  output reg cmdIsWrite,
  output reg [7:0] cmdCode,
  output reg [7:0] cmdWriteData,
  output reg clearFaultsCmd,
  // answer from the device
  input wire [7:0] readData_reg,
  input wire readValid_reg
);
  initial begin
    cmdStrobe = 1'b0;
    cmdIsWrite = 1'b0;
    cmdCode = 8'h00;
    cmdWriteData = 8'h00;
    clearFaultsCmd = 1'b0;
  end
  // code and data are inverted once released so a stale value can never pass
  task automatic issue(input logic wr, input logic [7:0] code, input logic [7:0] data,
                       output logic [7:0] rd, output logic ok);
    begin
      @(posedge clock);
      cmdStrobe <= 1'b1;
      cmdIsWrite <= wr;
      cmdCode <= code;
      cmdWriteData <= data;
      @(posedge clock);
      cmdStrobe <= 1'b0;
      cmdCode <= ~code;
      cmdWriteData <= ~data;
      #1;
      rd = readData_reg;
      ok = readValid_reg;
    end
  endtask
  task automatic clearAll;
    begin
      @(posedge clock);
      clearFaultsCmd <= 1'b1;
      @(posedge clock);
      clearFaultsCmd <= 1'b0;
    end
  endtask
endmodule // pmbus_host_model

// ===== tb/pmbus_fault_status_regs_tb_top.sv
`timescale 1ns/1ps
module pmbus_fault_status_regs_tb_top;
  reg clock = 1'b0;
  reg sys_rst = 1'b1;
  reg [13:0] evt = 14'h0000;
  reg powerInputOnAsync = 1'b0;
  reg bias5vOkAsync = 1'b0;
  reg [7:0] voutAlertMask = 8'h00;
  reg [2:0] alertMaskExt = 3'h0;
  reg [7:0] otherAlertMask = 8'h00;
  wire cmdStrobe, cmdIsWrite, clearFaultsCmd, readValid_reg, cmdRejected_reg;
  wire [7:0] cmdCode, cmdWriteData, readData_reg;
  wire voutSummary_reg, ioutSummary_reg, inputSummary_reg, tempSummary_reg, smbAlert_reg;
  wire [3:0] summaries = {tempSummary_reg, inputSummary_reg, ioutSummary_reg, voutSummary_reg};
  integer n_errors = 0;
  integer n_tests = 0;
  integer i;
  reg [7:0] rd;
  reg ok;
  always #20 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////////
  pmbus_host_model u_pmbus_host_model (.clock(clock), .cmdStrobe(cmdStrobe), .cmdIsWrite(cmdIsWrite),
    .cmdCode(cmdCode), .cmdWriteData(cmdWriteData), .clearFaultsCmd(clearFaultsCmd),
    .readData_reg(readData_reg), .readValid_reg(readValid_reg));
  // current, input and temperature bytes share one mask; each of their alert paths is still its own logic
  pmbus_fault_status_regs u_pmbus_fault_status_regs (.clock(clock), .sys_rst(sys_rst),
    .cmdStrobe(cmdStrobe), .cmdIsWrite(cmdIsWrite), .cmdCode(cmdCode), .cmdWriteData(cmdWriteData),
    .clearFaultsCmd(clearFaultsCmd), .readData_reg(readData_reg), .readValid_reg(readValid_reg),
    .cmdRejected_reg(cmdRejected_reg), .ovFixedEvt(evt[0]), .ovTrackingEvt(evt[1]), .ovPrebiasEvt(evt[2]),
    .outOvWarnEvt(evt[3]), .outUvWarnEvt(evt[4]), .outUvFaultEvt(evt[5]), .outLimitEvt(evt[6]),
    .startupTimeoutEvt(evt[7]), .overcurrentFaultEvt(evt[8]), .overcurrentWarnEvt(evt[9]),
    .overtempFaultEvt(evt[10]), .overtempWarnEvt(evt[11]), .inputOvFaultEvt(evt[12]),
    .inputUvWarnEvt(evt[13]), .powerInputOnAsync(powerInputOnAsync), .bias5vOkAsync(bias5vOkAsync),
    .voutAlertMask(voutAlertMask), .ioutAlertMask(otherAlertMask), .inputAlertMask(otherAlertMask),
    .tempAlertMask(otherAlertMask),
    .alertMaskExt(alertMaskExt), .voutSummary_reg(voutSummary_reg), .ioutSummary_reg(ioutSummary_reg),
    .inputSummary_reg(inputSummary_reg), .tempSummary_reg(tempSummary_reg), .smbAlert_reg(smbAlert_reg));
  ////////////////////////////////////////////////////////////////////////////////
  function [7:0] codeOf(input integer k);
    codeOf = (k < 8) ? 8'h7A : (k < 10) ? 8'h7B : (k < 12) ? 8'h7D : 8'h7C;
  endfunction
  function [7:0] bitOf(input integer k);
    bitOf = 8'h01 << ((k < 3) ? 7 : (k < 8) ? 9 - k : (k == 9 || k == 13) ? 5 : (k == 11) ? 6 : 7);
  endfunction
  task checkByte(input [8*12:1] what, input [7:0] exp, input [7:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task checkBit(input [8*12:1] what, input exp, input got);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED %0s expected %b seen %b", what, exp, got);
      end
    end
  endtask
  task readExpect(input [7:0] code, input [7:0] exp);
    begin
      u_pmbus_host_model.issue(1'b0, code, 8'h00, rd, ok);
      checkBit("readValid", 1'b1, ok);
      checkByte("readData", exp, rd);
    end
  endtask
  task writeByte(input [7:0] code, input [7:0] data);
    u_pmbus_host_model.issue(1'b1, code, data, rd, ok);
  endtask
  // the pulse lasts one cycle; return once flag, summary and alert have landed
  task pulse(input integer k);
    begin
      @(posedge clock);
      evt <= 14'h0001 << k;
      @(posedge clock);
      evt <= 14'h0000;
      repeat (2) @(posedge clock);
      #1;
    end
  endtask
  task rails(input p, input b);
    begin
      @(posedge clock);
      powerInputOnAsync <= p;
      bias5vOkAsync <= b;
      repeat (8) @(posedge clock);
    end
  endtask
  task setMasks(input [7:0] m, input [2:0] e);
    begin
      @(posedge clock);
      voutAlertMask <= m;
      alertMaskExt <= e;
    end
  endtask
  task tally_and_finish;
    begin
      if (n_errors == 0 && n_tests > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    n_errors = n_errors + 1;
    tally_and_finish;
  end
  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    readExpect(8'h7A, 8'h00);
    readExpect(8'h7B, 8'h00);
    readExpect(8'h7C, 8'h08);
    readExpect(8'h7D, 8'h00);
    pulse(13);
    readExpect(8'h7C, 8'h28);
    checkBit("smbAlert", 1'b0, smbAlert_reg);
    u_pmbus_host_model.clearAll;
    rails(1'b1, 1'b1);
    readExpect(8'h7C, 8'h00);
    rails(1'b1, 1'b0);
    readExpect(8'h7C, 8'h08);
    rails(1'b1, 1'b1);
    for (i = 0; i < 14; i = i + 1) begin
      pulse(i);
      checkBit("summary", 1'b1, summaries[codeOf(i) - 8'h7A]);
      checkBit("smbAlert", 1'b1, smbAlert_reg);
      writeByte(codeOf(i), 8'h00);
      readExpect(codeOf(i), bitOf(i));
      writeByte(codeOf(i), ~bitOf(i));
      readExpect(codeOf(i), bitOf(i));
      writeByte(codeOf(i), bitOf(i));
      repeat (2) @(posedge clock);
      #1;
      checkBit("summary", 1'b0, summaries[codeOf(i) - 8'h7A]);
      checkBit("smbAlert", 1'b0, smbAlert_reg);
      readExpect(codeOf(i), 8'h00);
    end
    setMasks(8'h10, 3'h0);
    pulse(5);
    checkBit("smbAlert", 1'b0, smbAlert_reg);
    readExpect(8'h7A, 8'h10);
    u_pmbus_host_model.clearAll;
    setMasks(8'h80, 3'h0);
    for (i = 0; i < 3; i = i + 1) begin
      pulse(i);
      checkBit("smbAlert", 1'b0, smbAlert_reg);
    end
    u_pmbus_host_model.clearAll;
    setMasks(8'h00, 3'h2);
    pulse(1);
    checkBit("smbAlert", 1'b0, smbAlert_reg);
    pulse(0);
    checkBit("smbAlert", 1'b1, smbAlert_reg);
    u_pmbus_host_model.clearAll;
    setMasks(8'h00, 3'h0);
    @(posedge clock);
    otherAlertMask <= 8'hFF;
    for (i = 8; i < 14; i = i + 1) begin
      pulse(i);
      checkBit("smbAlert", 1'b0, smbAlert_reg);
    end
    u_pmbus_host_model.clearAll;
    // a detector pulse in the same cycle as clear faults must survive
    fork
      u_pmbus_host_model.clearAll;
      pulse(6);
    join
    readExpect(8'h7A, 8'h08);
    // a reset in mid-run must wipe a flag that is still set
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    readExpect(8'h7A, 8'h00);
    checkBit("summary", 1'b0, voutSummary_reg);
    u_pmbus_host_model.clearAll;
    u_pmbus_host_model.issue(1'b0, 8'h7E, 8'h00, rd, ok);
    checkBit("readValid", 1'b0, ok);
    checkBit("cmdRejected", 1'b1, cmdRejected_reg);
    checkByte("readData", 8'h00, rd);
    tally_and_finish;
  end
endmodule // pmbus_fault_status_regs_tb_top
